// [hdl/sdw_defs.svh]
// command codes, timing counts and field positions for the sdram write path
`ifndef SDW_DEFS_SVH
`define SDW_DEFS_SVH
`define SDW_CMD_NOP 3'h7
`define SDW_CMD_ACT 3'h3
`define SDW_CMD_RD 3'h5
`define SDW_CMD_WR 3'h4
`define SDW_CMD_BST 3'h6
`define SDW_CMD_PRE 3'h2
`define SDW_CMD_REF 3'h1
`define SDW_CMD_LMR 3'h0
`define SDW_CLK_NS 20
`define SDW_TWR_NS 15
`define SDW_TRP_NS 20
`define SDW_TWR_CYC ((`SDW_TWR_NS + `SDW_CLK_NS - 1) / `SDW_CLK_NS + 1)
`define SDW_TRP_CYC ((`SDW_TRP_NS + `SDW_CLK_NS - 1) / `SDW_CLK_NS)
`define SDW_MODE_WBM_BIT 9
`define SDW_MODE_BL_LSB 0
`define SDW_BL_PAGE 3'h7
`define SDW_REG_CMD 32'h0000_0000
`define SDW_REG_ADDR 32'h0000_0004
`define SDW_REG_WDATA 32'h0000_0008
`define SDW_REG_STAT 32'h0000_000C
`define SDW_REG_RDATA 32'h0000_0010
`endif

// [hdl/sdw_pkg.sv]
// types for the two ends of the sdram write-path link: bank and power states for the device, fsm states for the controller
package sdw_pkg;
  typedef enum logic [1:0] {
    SDW_BANK_IDLE = 2'b00,
    SDW_BANK_ACTIVE = 2'b01,
    SDW_BANK_PRECH = 2'b10
  } sdw_bank_t;
  typedef enum logic [1:0] {
    SDW_DEV_RUN = 2'b00,
    SDW_DEV_PD_PRE = 2'b01,
    SDW_DEV_PD_ACT = 2'b10
  } sdw_dev_t;
  typedef enum logic [1:0] {
    SDW_CTL_IDLE = 2'b00,
    SDW_CTL_ISSUE = 2'b01,
    SDW_CTL_DONE = 2'b10
  } sdw_ctl_t;
endpackage

// [hdl/sdw_if.sv]
// pin bundle between the sdram device and its controller
`timescale 1ns/100ps
interface sdw_if #(parameter int DW = 16, parameter int AW = 12);
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic bank_select_low;
  logic bank_select_high;
  logic [AW-1:0] addr;
  logic dqm;
  logic [DW-1:0] dq_ctl_o;
  logic dq_ctl_oe;
  logic [DW-1:0] dq_dev_o;
  logic dq_dev_oe;
  logic [DW-1:0] dq;
  assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, addr, dqm,
    dq_ctl_o, dq_ctl_oe, output dq_dev_o, dq_dev_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, addr, dqm,
    dq_ctl_o, dq_ctl_oe, input dq_dev_o, dq_dev_oe);
endinterface

// [hdl/sdw_dev.sv]
// sdram device end: write bursts, truncation, precharge, power-down, clock suspend
//
// Design decisions made in sdw_ctl, not here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "sdw_defs.svh"
module sdw_dev #(
  parameter int DW = 16,
  parameter int AW = 12,
  parameter int CW = 8,
  parameter int RL = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  sdw_if.dev pins,
  input wire logic [AW-1:0] mode_word,
  output logic mem_we,
  output logic [1:0] mem_bank,
  output logic [CW-1:0] mem_col,
  output logic [DW-1:0] mem_wdata,
  input wire logic [DW-1:0] mem_rdata,
  output logic [3:0] bank_open,
  output logic power_down,
  output logic suspended
);
  typedef struct packed {
    sdw_pkg::sdw_dev_t pd;
    logic cke_prev;
    logic wr_act;
    logic rd_act;
    logic [1:0] bbank;
    logic [CW-1:0] col;
    logic [8:0] left;
    logic page;
    logic ap;
    logic [RL-1:0] rd_pipe;
    logic [DW-1:0] rd_data;
    logic dq_oe;
    logic [3:0] apd_wait;
    logic [1:0] apd_bank;
    sdw_pkg::sdw_bank_t [3:0] bank;
    logic [3:0][3:0] tmr;
    logic we;
    logic [1:0] wbank;
    logic [CW-1:0] wcol;
    logic [DW-1:0] wdata;
  } sdw_dev_st_t;
  sdw_dev_st_t st_q, st_d;
  logic [2:0] cmd;
  logic nopish;
  logic [1:0] cbank;
  logic [8:0] bl_words;
  logic run;
  logic [RL-1:0] rd_tap;
  function automatic logic [8:0] bl_decode(input logic [2:0] f);
    bl_decode = (f == `SDW_BL_PAGE) ? 9'h1FF : (9'h001 << f[1:0]);
  endfunction
  assign cmd = pins.cs_n ? `SDW_CMD_NOP : {pins.ras_n, pins.cas_n, pins.we_n};
  assign nopish = (cmd == `SDW_CMD_NOP);
  assign cbank = {pins.bank_select_high, pins.bank_select_low};
  assign bl_words = mode_word[`SDW_MODE_WBM_BIT] ? 9'h001 : bl_decode(mode_word[2:0]);
  // suspend only freezes an edge if cke was low at the previous edge
  assign run = st_q.cke_prev;
  // tap 0 is the command edge itself, so data drives read_latency edges after it
  assign rd_tap = {st_q.rd_pipe[RL-2:0], st_q.rd_act};
  always_comb begin
    st_d = st_q;
    st_d.cke_prev = pins.cke;
    st_d.we = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (st_q.bank[b] == sdw_pkg::SDW_BANK_PRECH) begin
        if (st_q.tmr[b] <= 4'h1) begin
          st_d.bank[b] = sdw_pkg::SDW_BANK_IDLE;
          st_d.tmr[b] = 4'h0;
        end else begin
          st_d.tmr[b] = st_q.tmr[b] - 4'h1;
        end
      end
    end
    if (st_q.apd_wait != 4'h0) begin
      st_d.apd_wait = st_q.apd_wait - 4'h1;
      if (st_q.apd_wait == 4'h1) begin
        st_d.bank[st_q.apd_bank] = sdw_pkg::SDW_BANK_PRECH;
        st_d.tmr[st_q.apd_bank] = 4'(`SDW_TRP_CYC);
      end
    end
    if (st_q.pd != sdw_pkg::SDW_DEV_RUN) begin
      if (pins.cke && nopish) begin
        st_d.pd = sdw_pkg::SDW_DEV_RUN;
      end
    end else if (!run) begin
      // frozen edge: burst column, count and data stay put; bank timers still count and mem_we drops
      st_d.cke_prev = pins.cke;
    end else if (!pins.cke && nopish && !st_q.wr_act && !st_q.rd_act) begin
      st_d.pd = (st_q.bank == '0) ? sdw_pkg::SDW_DEV_PD_PRE : sdw_pkg::SDW_DEV_PD_ACT;
    end else begin
      st_d.rd_pipe = {st_q.rd_pipe[RL-2:0], st_q.rd_act};
      st_d.dq_oe = rd_tap[RL-2];
      st_d.rd_data = mem_rdata;
      if (st_q.wr_act) begin
        if (!pins.dqm) begin
          st_d.we = 1'b1;
          st_d.wbank = st_q.bbank;
          st_d.wcol = st_q.col;
          st_d.wdata = pins.dq_ctl_o;
        end
        st_d.col = st_q.col + 1'b1;
        if (!st_q.page) begin
          st_d.left = st_q.left - 9'h001;
          if (st_q.left == 9'h001) begin
            st_d.wr_act = 1'b0;
            if (st_q.ap) begin
              st_d.apd_wait = 4'(`SDW_TWR_CYC);
              st_d.apd_bank = st_q.bbank;
            end
          end
        end
      end else if (st_q.rd_act) begin
        st_d.col = st_q.col + 1'b1;
        if (!st_q.page) begin
          st_d.left = st_q.left - 9'h001;
          if (st_q.left == 9'h001) begin
            st_d.rd_act = 1'b0;
            if (st_q.ap) begin
              st_d.bank[st_q.bbank] = sdw_pkg::SDW_BANK_PRECH;
              st_d.tmr[st_q.bbank] = 4'(`SDW_TRP_CYC);
            end
          end
        end
      end
      case (cmd)
        `SDW_CMD_ACT: st_d.bank[cbank] = sdw_pkg::SDW_BANK_ACTIVE;
        `SDW_CMD_WR, `SDW_CMD_RD: begin
          if (st_q.ap && (st_q.wr_act || st_q.rd_act) && st_q.bbank != cbank) begin
            if (st_q.wr_act) begin
              st_d.apd_wait = 4'(`SDW_TWR_CYC);
              st_d.apd_bank = st_q.bbank;
            end else begin
              st_d.bank[st_q.bbank] = sdw_pkg::SDW_BANK_PRECH;
              st_d.tmr[st_q.bbank] = 4'(`SDW_TRP_CYC);
            end
          end
          st_d.bbank = cbank;
          st_d.ap = pins.addr[10];
          st_d.page = (mode_word[2:0] == `SDW_BL_PAGE) &&
            !(cmd == `SDW_CMD_WR && mode_word[`SDW_MODE_WBM_BIT]);
          if (cmd == `SDW_CMD_WR) begin
            // first word is written on the command edge itself
            st_d.wr_act = (bl_words != 9'h001);
            st_d.rd_act = 1'b0;
            st_d.left = bl_words - 9'h001;
            st_d.col = pins.addr[CW-1:0] + 1'b1;
            st_d.dq_oe = 1'b0;
            st_d.rd_pipe = '0;
            if (!pins.dqm) begin
              st_d.we = 1'b1;
              st_d.wbank = cbank;
              st_d.wcol = pins.addr[CW-1:0];
              st_d.wdata = pins.dq_ctl_o;
            end
            if (bl_words == 9'h001 && pins.addr[10]) begin
              st_d.apd_wait = 4'(`SDW_TWR_CYC);
              st_d.apd_bank = cbank;
            end
          end else begin
            st_d.wr_act = 1'b0;
            st_d.we = 1'b0;
            st_d.rd_act = 1'b1;
            st_d.left = mode_word[2:0] == `SDW_BL_PAGE ? 9'h1FF : bl_decode(mode_word[2:0]);
            st_d.col = pins.addr[CW-1:0];
          end
        end
        `SDW_CMD_BST: begin
          st_d.wr_act = 1'b0;
          st_d.we = 1'b0;
          st_d.rd_act = 1'b0;
        end
        `SDW_CMD_PRE: begin
          st_d.wr_act = 1'b0;
          st_d.we = 1'b0;
          st_d.rd_act = 1'b0;
          for (int b = 0; b < 4; b++) begin
            if (pins.addr[10] || cbank == 2'(b)) begin
              st_d.bank[b] = sdw_pkg::SDW_BANK_PRECH;
              st_d.tmr[b] = 4'(`SDW_TRP_CYC);
            end
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      // matches the controller's idle cke, else reset looks like a suspend
      st_q.cke_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
  assign pins.dq_dev_o = st_q.rd_data;
  assign pins.dq_dev_oe = st_q.dq_oe && (st_q.pd == sdw_pkg::SDW_DEV_RUN);
  assign mem_we = st_q.we;
  assign mem_bank = st_q.wbank;
  assign mem_col = st_q.wcol;
  assign mem_wdata = st_q.wdata;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bank_open[b] = (st_q.bank[b] == sdw_pkg::SDW_BANK_ACTIVE);
    end
  end
  assign power_down = (st_q.pd != sdw_pkg::SDW_DEV_RUN);
  assign suspended = !st_q.cke_prev && !power_down;
endmodule

// [hdl/sdw_ctl.sv]
// sdram controller end: ahb-lite slave registers driving one command per request
`timescale 1ns/100ps
`include "sdw_defs.svh"
module sdw_ctl #(
  parameter int DW = 16,
  parameter int AW = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  sdw_if.ctl pins
);
  typedef struct packed {
    sdw_pkg::sdw_ctl_t fsm;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [5:0] cmd_reg;
    logic [AW+1:0] addr_reg;
    logic [DW-1:0] wdata_reg;
    logic [DW-1:0] rdata_reg;
    logic [3:0] wait_cnt;
    logic cke;
    logic [2:0] cmd;
    logic [1:0] bank;
    logic [AW-1:0] addr;
    logic dqm;
    logic [DW-1:0] dq;
    logic dq_oe;
  } sdw_ctl_st_t;
  sdw_ctl_st_t st_q, st_d;
  // cmd register: [2:0] command, [3] cke, [4] dqm, [5] go
  always_comb begin
    st_d = st_q;
    st_d.ph_valid = hsel && htrans[1] && hready;
    st_d.ph_write = hwrite;
    st_d.ph_addr = haddr[7:0];
    if (st_q.ph_valid && st_q.ph_write) begin
      if ({24'h0, st_q.ph_addr} == `SDW_REG_CMD) begin
        st_d.cmd_reg = hwdata[5:0];
      end else if ({24'h0, st_q.ph_addr} == `SDW_REG_ADDR) begin
        st_d.addr_reg = hwdata[AW+1:0];
      end else if ({24'h0, st_q.ph_addr} == `SDW_REG_WDATA) begin
        st_d.wdata_reg = hwdata[DW-1:0];
      end
    end
    if (pins.dq_dev_oe) begin
      st_d.rdata_reg = pins.dq_dev_o;
    end
    st_d.cmd = `SDW_CMD_NOP;
    st_d.dq_oe = 1'b0;
    case (st_q.fsm)
      sdw_pkg::SDW_CTL_IDLE: begin
        if (st_q.cmd_reg[5]) begin
          st_d.fsm = sdw_pkg::SDW_CTL_ISSUE;
        end
      end
      sdw_pkg::SDW_CTL_ISSUE: begin
        st_d.cmd = st_q.cmd_reg[2:0];
        st_d.cke = st_q.cmd_reg[3];
        st_d.dqm = st_q.cmd_reg[4];
        st_d.bank = st_q.addr_reg[AW+1:AW];
        st_d.addr = st_q.addr_reg[AW-1:0];
        st_d.dq = st_q.wdata_reg;
        // only writes drive the bus; other commands may meet device read data
        st_d.dq_oe = (st_q.cmd_reg[2:0] == `SDW_CMD_WR);
        st_d.cmd_reg[5] = 1'b0;
        // spacing covers write recovery and precharge period
        st_d.wait_cnt = 4'(`SDW_TRP_CYC + `SDW_TWR_CYC);
        st_d.fsm = sdw_pkg::SDW_CTL_DONE;
      end
      default: begin
        st_d.wait_cnt = st_q.wait_cnt - 4'h1;
        if (st_q.wait_cnt == 4'h1) begin
          st_d.fsm = sdw_pkg::SDW_CTL_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.cke <= 1'b1;
      st_q.cmd <= `SDW_CMD_NOP;
    end else begin
      st_q <= st_d;
    end
  end
  always_comb begin
    hrdata = 32'h0000_0000;
    if ({24'h0, st_q.ph_addr} == `SDW_REG_CMD) begin
      hrdata = {26'h0, st_q.cmd_reg};
    end else if ({24'h0, st_q.ph_addr} == `SDW_REG_ADDR) begin
      hrdata = 32'(st_q.addr_reg);
    end else if ({24'h0, st_q.ph_addr} == `SDW_REG_WDATA) begin
      hrdata = 32'(st_q.wdata_reg);
    end else if ({24'h0, st_q.ph_addr} == `SDW_REG_STAT) begin
      hrdata = {30'h0, st_q.fsm};
    end else if ({24'h0, st_q.ph_addr} == `SDW_REG_RDATA) begin
      hrdata = 32'(st_q.rdata_reg);
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pins.cke = st_q.cke;
  assign pins.cs_n = 1'b0;
  assign pins.ras_n = st_q.cmd[2];
  assign pins.cas_n = st_q.cmd[1];
  assign pins.we_n = st_q.cmd[0];
  assign pins.bank_select_high = st_q.bank[1];
  assign pins.bank_select_low = st_q.bank[0];
  assign pins.addr = st_q.addr;
  assign pins.dqm = st_q.dqm;
  assign pins.dq_ctl_o = st_q.dq;
  assign pins.dq_ctl_oe = st_q.dq_oe;
endmodule

// [tb/sdw_chk.sv]
// concurrent checks on the sdram command and data pins
`timescale 1ns/100ps
`include "sdw_defs.svh"
module sdw_chk #(
  parameter int RL = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic dqm,
  input wire logic dq_ctl_oe,
  input wire logic dq_dev_oe
);
  logic [2:0] cmd;
  logic busy;
  logic is_wr;
  logic is_rd;
  logic is_pre;
  assign cmd = {ras_n, cas_n, we_n};
  assign busy = !cs_n && cmd != `SDW_CMD_NOP;
  assign is_wr = busy && cke && cmd == `SDW_CMD_WR;
  assign is_rd = busy && cke && cmd == `SDW_CMD_RD;
  assign is_pre = busy && cmd == `SDW_CMD_PRE;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // spacing covers both recovery and precharge waits
  cmd_spacing_a: assert property (busy |=> !busy [*2]) else $error("commands closer than three cycles");
  wr_no_pre_a: assert property (is_wr |-> ##1 !is_pre ##1 !is_pre) else $error("precharge inside recovery");
  wr_data_a: assert property (is_wr && !dqm |-> dq_ctl_oe) else $error("write word not driven");
  wr_bus_free_a: assert property (is_wr |=> !dq_dev_oe [*2]) else $error("device drives during write");
  no_contention_a: assert property (!(dq_ctl_oe && dq_dev_oe)) else $error("both ends drive data");
  rd_latency_a: assert property (is_rd |-> ##RL dq_dev_oe) else $error("read data late");
  pd_entry_a: assert property ($fell(cke) |-> !busy) else $error("clock enable fell with a command");
  pd_exit_a: assert property ($rose(cke) |-> !busy) else $error("clock enable rose with a command");
endmodule

// [tb/tb.sv]
// self-checking bench joining device and controller ends through the pin bundle
`timescale 1ns/100ps
`include "sdw_defs.svh"
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] mode_word;
  logic mem_we, power_down, suspended;
  logic [1:0] mem_bank;
  logic [7:0] mem_col;
  logic [15:0] mem_wdata, mem_rdata, wd, rd;
  logic [3:0] bank_open;
  logic [7:0] got_col[$];
  logic [17:0] got_bd[$];
  int failures = 0;
  int total_checks = 0;
  sdw_if #(.DW(16), .AW(12)) link ();
  sdw_ctl sdw_ctl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pins(link));
  sdw_dev #(.RL(2)) sdw_dev_inst (.hclk(hclk), .hresetn(hresetn), .pins(link), .mode_word(mode_word),
    .mem_we(mem_we), .mem_bank(mem_bank), .mem_col(mem_col), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .bank_open(bank_open), .power_down(power_down), .suspended(suspended));
  sdw_chk #(.RL(2)) sdw_chk_inst (.hclk(hclk), .hresetn(hresetn), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .dqm(link.dqm), .dq_ctl_oe(link.dq_ctl_oe),
    .dq_dev_oe(link.dq_dev_oe));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // stored words as the model sees them, in arrival order
  always @(posedge hclk) begin
    if (mem_we === 1'b1) begin
      got_col.push_back(mem_col);
      got_bd.push_back({mem_bank, mem_wdata});
    end
  end
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // one command through the registers, then time for it to reach the pins
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic ck, input logic m);
    logic [31:0] r;
    ahb(1'b1, `SDW_REG_ADDR, {18'h0_0000, b, a}, r);
    ahb(1'b1, `SDW_REG_CMD, {26'h000_0000, 1'b1, m, ck, c}, r);
    repeat (12) @(posedge hclk);
  endtask
  task automatic write(input logic [1:0] b, input logic [11:0] a, input logic m);
    logic [31:0] r;
    wd = 16'($urandom);
    ahb(1'b1, `SDW_REG_WDATA, {16'h0000, wd}, r);
    cmd(`SDW_CMD_WR, b, a, 1'b1, m);
  endtask
  // n below zero: length open, column order, bank and first word are still compared
  task automatic burst(input logic [1:0] b, input logic [7:0] c, input int n);
    if (n >= 0) check(got_col.size(), n);
    foreach (got_col[i]) begin
      check(got_col[i], 8'(c + i));
      check(got_bd[i][17:16], b);
    end
    if (got_bd.size() > 0) check(got_bd[0][15:0], wd);
    got_col.delete();
    got_bd.delete();
  endtask
  task automatic hold_count(); // words stop arriving
    int n;
    n = got_col.size();
    repeat (4) @(posedge hclk);
    check(got_col.size(), n);
  endtask
  initial begin
    logic [31:0] r;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    mode_word = 12'h000;
    mem_rdata = 16'h0000;
    void'($urandom(32'h1526));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0000_0020, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    ahb(1'b1, `SDW_REG_ADDR, 32'h0000_2ABC, r);
    ahb(1'b0, `SDW_REG_ADDR, 32'h0000_0000, r);
    check(r, 32'h0000_2ABC);
    cmd(`SDW_CMD_ACT, 2'h1, 12'h015, 1'b1, 1'b0);
    cmd(`SDW_CMD_ACT, 2'h2, 12'h02A, 1'b1, 1'b0);
    check(bank_open, 4'h6);
    // single-write mode with a long programmed burst, plain then masked
    for (int m = 0; m < 2; m++) begin
      mode_word <= 12'h203;
      write(2'h1, 12'h040, m[0]);
      burst(2'h1, 8'h40, m ? 0 : 1);
    end
    mode_word <= 12'h002;
    write(2'h2, 12'h008, 1'b0);
    burst(2'h2, 8'h08, 4);
    // full page crossing the page end, suspended, then terminated
    mode_word <= 12'h007;
    write(2'h1, 12'h0FA, 1'b0);
    cmd(`SDW_CMD_NOP, 2'h0, 12'h000, 1'b0, 1'b0);
    check(suspended, 1'b1);
    check(power_down, 1'b0);
    hold_count();
    cmd(`SDW_CMD_NOP, 2'h0, 12'h000, 1'b1, 1'b0);
    check(suspended, 1'b0);
    cmd(`SDW_CMD_BST, 2'h1, 12'h000, 1'b1, 1'b0);
    hold_count();
    check(got_col.size() > 9, 1'b1);
    burst(2'h1, 8'hFA, -1);
    rd = 16'($urandom);
    mem_rdata <= rd;
    write(2'h1, 12'h000, 1'b0);
    cmd(`SDW_CMD_RD, 2'h1, 12'h000, 1'b1, 1'b0);
    hold_count();
    burst(2'h1, 8'h00, -1);
    ahb(1'b0, `SDW_REG_RDATA, 32'h0000_0000, r);
    check(r, {16'h0000, rd});
    cmd(`SDW_CMD_PRE, 2'h1, 12'h000, 1'b1, 1'b0);
    check(bank_open, 4'h4);
    cmd(`SDW_CMD_PRE, 2'h1, 12'h400, 1'b1, 1'b0);
    check(bank_open, 4'h0);
    cmd(`SDW_CMD_NOP, 2'h0, 12'h000, 1'b0, 1'b0);
    check(power_down, 1'b1);
    cmd(`SDW_CMD_NOP, 2'h0, 12'h000, 1'b1, 1'b0);
    check(power_down, 1'b0);
    final_report();
  end
  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge hclk);
    failures++;
    final_report();
  end
endmodule
